// ===== src/dat_pkg.sv
package dat_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL_LOW = 8'hD0;
	localparam logic [7:0] OFS_CTRL_HIGH = 8'hD4;
	localparam logic [7:0] OFS_STATUS = 8'hD8;
	localparam logic [31:0] CTRL_LOW_RST = 32'h2000_0000;
	localparam logic [31:0] CTRL_HIGH_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_LOW_MASK = 32'h3FFF_FFFF;
	localparam logic [31:0] CTRL_HIGH_MASK = 32'hE01F_FFFF;
	// ----------------------------------------
	// field positions and widths
	// ----------------------------------------
	localparam int CL_WT_LO = 28;
	localparam int CL_WT_W = 2;
	localparam int CL_TT_LO = 22;
	localparam int CL_TT_W = 6;
	localparam int CL_TMW_LO = 15;
	localparam int CL_TMW_W = 7;
	localparam int CL_TAM_LO = 3;
	localparam int CL_TAM_W = 12;
	localparam int CL_MODE_LO = 1;
	localparam int CL_ST = 0;
	localparam int CH_LOCK_LO = 30;
	localparam int CH_TEST = 29;
	localparam int CH_GSW_LO = 13;
	localparam int CH_GSW_W = 8;
	localparam int CH_GAT_LO = 0;
	localparam int CH_GAT_W = 13;
	localparam int GAT_SHIFT = 15;
	localparam int GAT_SHIFT_TEST = 5;
	localparam int TMW_SHIFT = 4;
	localparam int GSW_MULT_SHIFT = 2;
	localparam int GLB_W = 29;
	localparam int MON_W = 13;
	localparam logic [1:0] RW_WEIGHT = 2'h2;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_CNT = 2'h2;
	localparam logic [1:0] LOCK_NONE = 2'h0;
	localparam logic [1:0] LOCK_START = 2'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int T_MS_NS = 1000000;
	localparam int T_US_NS = 1000;
	localparam int MS_CYC = T_MS_NS / CLK_PERIOD_NS;
	localparam int US_CYC = T_US_NS / CLK_PERIOD_NS;
	typedef enum logic [0:0] {
		DAT_MON,
		DAT_HW
	} dat_state_t;
endpackage

// ===== src/dat_cnt_if.sv
`timescale 1ns/1ps
interface dat_cnt_if #(parameter int NSLOT = 4);
	localparam int SW = (NSLOT > 1) ? $clog2(NSLOT) : 1;
	logic ce;
	logic act_v;
	logic [SW-1:0] act_slot;
	logic rw_v;
	logic [SW-1:0] rw_slot;
	logic [2:0] act_wt;
	logic mon_clr;
	logic glb_clr;
	logic [11:0] slot_activity_max;
	logic [27:0] gthr;
	logic mon_hit;
	logic glb_hit;
	modport ctl (
		output ce, act_v, act_slot, rw_v, rw_slot, act_wt, mon_clr, glb_clr, slot_activity_max, gthr,
		input mon_hit, glb_hit
	);
	modport ctr (
		input ce, act_v, act_slot, rw_v, rw_slot, act_wt, mon_clr, glb_clr, slot_activity_max, gthr,
		output mon_hit, glb_hit
	);
endinterface

// ===== src/dat_slot_ctr.sv
`timescale 1ns/1ps
module dat_slot_ctr #(
	parameter int NSLOT = 4
) (
	input wire logic clk,
	input wire logic rstn,
	dat_cnt_if.ctr c
);
	// ----------------------------------------
	// per-slot weighted counters
	// ----------------------------------------
	logic [dat_pkg::MON_W-1:0] mon_q [NSLOT];
	logic [dat_pkg::GLB_W-1:0] glb_q [NSLOT];

	// saturating add keeps a long window from wrapping back under the threshold
	function automatic logic [dat_pkg::GLB_W-1:0] sat_add(
		input logic [dat_pkg::GLB_W-1:0] a, input logic [2:0] w, input int unsigned lim);
		logic [dat_pkg::GLB_W:0] s;
		s = {1'b0, a} + {{(dat_pkg::GLB_W-2){1'b0}}, w};
		if (s > lim)
			s = lim[dat_pkg::GLB_W:0];
		return s[dat_pkg::GLB_W-1:0];
	endfunction

	function automatic logic [2:0] slot_inc(input int s);
		logic [2:0] w;
		w = 3'h0;
		if (c.act_v && c.act_slot == s[$bits(c.act_slot)-1:0])
			w = c.act_wt;
		if (c.rw_v && c.rw_slot == s[$bits(c.rw_slot)-1:0])
			w = 3'({1'b0, dat_pkg::RW_WEIGHT});
		return w;
	endfunction

	function automatic logic [dat_pkg::GLB_W-1:0] glb_ext(input logic [dat_pkg::MON_W-1:0] v);
		return {{(dat_pkg::GLB_W-dat_pkg::MON_W){1'b0}}, v};
	endfunction

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NSLOT; i++) begin
				mon_q[i] <= '0;
				glb_q[i] <= '0;
			end
		end else if (c.ce) begin
			// each slot updates on its own, so an activate and a read/write to two slots both land
			for (int i = 0; i < NSLOT; i++) begin
				if (c.mon_clr)
					mon_q[i] <= '0;
				else
					mon_q[i] <= dat_pkg::MON_W'(sat_add(glb_ext(mon_q[i]), slot_inc(i), 4096));
				if (c.glb_clr)
					glb_q[i] <= '0;
				else
					glb_q[i] <= sat_add(glb_q[i], slot_inc(i), (1 << dat_pkg::GLB_W) - 1);
			end
		end
	end

	always_comb begin
		c.mon_hit = 1'b0;
		c.glb_hit = 1'b0;
		for (int i = 0; i < NSLOT; i++) begin
			if (mon_q[i] >= {1'b0, c.slot_activity_max})
				c.mon_hit = 1'b1;
			if (glb_q[i] > {1'b0, c.gthr})
				c.glb_hit = 1'b1;
		end
	end
endmodule

// ===== src/dat_throttle.sv
`timescale 1ns/1ps
// Functional notes
// - only activate, read and write commands are counted.
// - every read or write adds two to its slot counter.
// - activate weight set by two-bit field, codes give 2..5, reset code 10.
// - read/write and activate to different slots in one cycle both count.
// - each DIMM slot has its own activity counter.
// - a block caused by any slot stops requests to all slots.
// - six-bit duration gives throttling length in global sampling windows.
// - seven-bit monitor window shifted left four gives window in host clocks.
// - slot reaching activity maximum blocks all slots until window end.
// - twelve-bit field holds per-slot activity maximum per monitor window.
// - mode 00 disables counter mechanism, 10 enables it, others reserved.
// - in mode 10 threshold hit starts duration-governed throttling cycles.
// - start bit set to one throttles until software clears it.
// - writing start bit zero stops throttling and clears monitor counters.
// - eight-bit global window times four gives window in milliseconds.
// - thirteen-bit global threshold times two to fifteen is trigger count.
// - slot exceeding global threshold within global window invokes throttling.
// - lock 01 leaves only start bit writable, 10 locks everything.
module dat_throttle #(
	parameter int NSLOT = 4,
	parameter int MS_CYCLES = dat_pkg::MS_CYC,
	parameter int US_CYCLES = dat_pkg::US_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cmd_act_valid,
	input wire logic [$clog2(NSLOT)-1:0] cmd_act_slot,
	input wire logic cmd_rw_valid,
	input wire logic [$clog2(NSLOT)-1:0] cmd_rw_slot,
	output logic req_block_q,
	output logic throttle_on_q
);
	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	logic [31:0] ctrl_low_q;
	logic [31:0] ctrl_high_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_held_q;
	logic w_held_q;
	logic do_wr;
	logic wr_lo;
	logic wr_hi;
	logic st_clr_q;
	dat_pkg::dat_state_t state_q;
	logic [5:0] rem_q;
	logic [31:0] pre_q;
	logic ms_tick;
	logic [9:0] gw_q;
	logic gw_end;
	logic [10:0] mw_q;
	logic mw_end;
	logic thr;
	logic [1:0] mode;
	logic [1:0] lock;
	logic [9:0] gw_len;
	logic [10:0] mw_len;

	dat_cnt_if #(.NSLOT(NSLOT)) cif ();

	dat_slot_ctr #(.NSLOT(NSLOT)) u_ctr (
		.clk(clk),
		.rstn(rstn),
		.c(cif.ctr)
	);

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	assign mode = ctrl_low_q[dat_pkg::CL_MODE_LO +: 2];
	assign lock = ctrl_high_q[dat_pkg::CH_LOCK_LO +: 2];
	assign gw_len = {ctrl_high_q[dat_pkg::CH_GSW_LO +: dat_pkg::CH_GSW_W], 2'h0};
	assign mw_len = {ctrl_low_q[dat_pkg::CL_TMW_LO +: dat_pkg::CL_TMW_W], 4'h0};
	// either the hardware trigger or the software start holds throttling on
	assign thr = (state_q == dat_pkg::DAT_HW) || ctrl_low_q[dat_pkg::CL_ST];

	assign cif.ce = ce;
	assign cif.act_v = cmd_act_valid;
	assign cif.act_slot = cmd_act_slot;
	assign cif.rw_v = cmd_rw_valid;
	assign cif.rw_slot = cmd_rw_slot;
	assign cif.act_wt = 3'h2 + {1'b0, ctrl_low_q[dat_pkg::CL_WT_LO +: dat_pkg::CL_WT_W]};
	assign cif.slot_activity_max = ctrl_low_q[dat_pkg::CL_TAM_LO +: dat_pkg::CL_TAM_W];
	// test mode scales the threshold down so a bench sees it quickly
	assign cif.gthr = ctrl_high_q[dat_pkg::CH_TEST] ?
		28'({ctrl_high_q[dat_pkg::CH_GAT_LO +: dat_pkg::CH_GAT_W], 5'h00}) :
		{ctrl_high_q[dat_pkg::CH_GAT_LO +: dat_pkg::CH_GAT_W], 15'h0000};
	assign cif.mon_clr = !thr || mw_end || st_clr_q;
	assign cif.glb_clr = gw_end || (state_q == dat_pkg::DAT_HW) || mode != dat_pkg::MODE_CNT;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// only word bits are compared, so a byte offset inside a word aliases to that word
	function automatic logic reg_sel(input logic [7:0] a, input logic [7:0] ofs);
		return a[7:2] == ofs[7:2];
	endfunction

	function automatic logic reg_known(input logic [7:0] a);
		return reg_sel(a, dat_pkg::OFS_CTRL_LOW) || reg_sel(a, dat_pkg::OFS_CTRL_HIGH)
			|| reg_sel(a, dat_pkg::OFS_STATUS);
	endfunction

	// ----------------------------------------
	// bus write path
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r & mask;
	endfunction

	assign do_wr = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_lo = do_wr && reg_sel(awaddr_q, dat_pkg::OFS_CTRL_LOW);
	assign wr_hi = do_wr && reg_sel(awaddr_q, dat_pkg::OFS_CTRL_HIGH);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_held_q <= 1'b0;
			s_axi_awready <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				s_axi_awready <= 1'b0;
				awaddr_q <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_held_q <= 1'b0;
				s_axi_awready <= 1'b1;
			end else if (!aw_held_q) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			w_held_q <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (do_wr) begin
				w_held_q <= 1'b0;
				s_axi_wready <= 1'b1;
			end else if (!w_held_q) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dat_pkg::RESP_OKAY;
		end else if (ce) begin
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				if (reg_known(awaddr_q))
					s_axi_bresp <= dat_pkg::RESP_OKAY;
				else
					s_axi_bresp <= dat_pkg::RESP_DECERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// configuration registers with lock
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_low_q <= dat_pkg::CTRL_LOW_RST;
			ctrl_high_q <= dat_pkg::CTRL_HIGH_RST;
			st_clr_q <= 1'b0;
		end else if (ce) begin
			st_clr_q <= 1'b0;
			if (wr_lo) begin
				if (lock == dat_pkg::LOCK_NONE)
					ctrl_low_q <= merge(ctrl_low_q, wdata_q, wstrb_q, dat_pkg::CTRL_LOW_MASK);
				else if (lock == dat_pkg::LOCK_START && wstrb_q[0])
					ctrl_low_q[dat_pkg::CL_ST] <= wdata_q[dat_pkg::CL_ST];
				// a stop restarts the monitor window from clean counts
				if (wstrb_q[0] && !wdata_q[dat_pkg::CL_ST] && lock[1] == 1'b0)
					st_clr_q <= 1'b1;
			end
			if (wr_hi && lock == dat_pkg::LOCK_NONE)
				ctrl_high_q <= merge(ctrl_high_q, wdata_q, wstrb_q, dat_pkg::CTRL_HIGH_MASK);
		end
	end

	// ----------------------------------------
	// bus read path
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= dat_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= dat_pkg::RESP_OKAY;
				unique case (s_axi_araddr[7:2])
					dat_pkg::OFS_CTRL_LOW[7:2]: s_axi_rdata <= ctrl_low_q;
					dat_pkg::OFS_CTRL_HIGH[7:2]: s_axi_rdata <= ctrl_high_q;
					dat_pkg::OFS_STATUS[7:2]: s_axi_rdata <= {23'h000000, rem_q, req_block_q,
						state_q == dat_pkg::DAT_HW, thr};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= dat_pkg::RESP_DECERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// millisecond prescaler and global window
	// ----------------------------------------
	assign ms_tick = ctrl_high_q[dat_pkg::CH_TEST] ? (pre_q >= 32'(US_CYCLES - 1)) :
		(pre_q >= 32'(MS_CYCLES - 1));
	assign gw_end = ms_tick && gw_len != 10'h000 && gw_q >= gw_len - 10'h001;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			pre_q <= 32'h0000_0000;
		else if (ce)
			pre_q <= (ms_tick || mode != dat_pkg::MODE_CNT) ? 32'h0000_0000 : pre_q + 32'h0000_0001;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			gw_q <= 10'h000;
		else if (ce) begin
			if (mode != dat_pkg::MODE_CNT || gw_end)
				gw_q <= 10'h000;
			else if (ms_tick)
				gw_q <= gw_q + 10'h001;
		end
	end

	// ----------------------------------------
	// hardware throttle sequencing
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= dat_pkg::DAT_MON;
			rem_q <= 6'h00;
		end else if (ce) begin
			unique case (state_q)
				dat_pkg::DAT_MON: begin
					if (mode == dat_pkg::MODE_CNT && cif.glb_hit) begin
						state_q <= dat_pkg::DAT_HW;
						rem_q <= ctrl_low_q[dat_pkg::CL_TT_LO +: dat_pkg::CL_TT_W];
					end
				end
				dat_pkg::DAT_HW: begin
					// a duration of zero still ends at the next window boundary
					if (mode != dat_pkg::MODE_CNT) begin
						state_q <= dat_pkg::DAT_MON;
						rem_q <= 6'h00;
					end else if (gw_end) begin
						if (rem_q <= 6'h01) begin
							state_q <= dat_pkg::DAT_MON;
							rem_q <= 6'h00;
						end else begin
							rem_q <= rem_q - 6'h01;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// monitor window and request blocking
	// ----------------------------------------
	assign mw_end = thr && mw_len != 11'h000 && mw_q >= mw_len - 11'h001;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			mw_q <= 11'h000;
		else if (ce) begin
			if (!thr || mw_end || st_clr_q)
				mw_q <= 11'h000;
			else
				mw_q <= mw_q + 11'h001;
		end
	end

	// one global block: the scheduler stalls every slot, not just the hot one
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			req_block_q <= 1'b0;
			throttle_on_q <= 1'b0;
		end else if (ce) begin
			throttle_on_q <= thr;
			if (!thr || mw_end || st_clr_q)
				req_block_q <= 1'b0;
			else if (cif.mon_hit && mw_len != 11'h000)
				req_block_q <= 1'b1;
		end
	end
endmodule

// ===== sim/dat_checker.sv
`timescale 1ns/1ps
module dat_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic req_block_q,
	input wire logic throttle_on_q
);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [11:0] blk_cnt_q;
	logic mapped;
	assign mapped = s_axi_araddr inside {dat_pkg::OFS_CTRL_LOW, dat_pkg::OFS_CTRL_HIGH, dat_pkg::OFS_STATUS};
	// longest window is 2032 clocks, so a block longer than 2048 is stuck
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			blk_cnt_q <= 12'h000;
		end else if (req_block_q && blk_cnt_q != 12'hFFF) begin
			blk_cnt_q <= blk_cnt_q + 12'h001;
		end else if (!req_block_q) begin
			blk_cnt_q <= 12'h000;
		end
	end
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_b_after_wr: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during read");
	a_r_unmapped: assert property (s_axi_arvalid && s_axi_arready && !mapped |=>
		s_axi_rresp == dat_pkg::RESP_DECERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_r_mapped: assert property (s_axi_arvalid && s_axi_arready && mapped |=> s_axi_rresp == dat_pkg::RESP_OKAY)
		else $error("mapped read refused");
	a_block_needs_on: assert property ($rose(req_block_q) |-> ##[0:1] throttle_on_q)
		else $error("block without throttling");
	a_off_unblocks: assert property ($fell(throttle_on_q) |-> ##[0:1] !req_block_q)
		else $error("block outlives throttling");
	a_block_window: assert property (blk_cnt_q <= 12'h800)
		else $error("block outlasts monitor window");
endmodule
bind dat_throttle dat_checker u_chk (.clk(clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .req_block_q(req_block_q), .throttle_on_q(throttle_on_q));

// ===== sim/dat_sched_model.sv
`timescale 1ns/1ps
module dat_sched_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic req_block_q,
	input wire logic want_act,
	input wire logic [1:0] want_act_slot,
	input wire logic want_rw,
	input wire logic [1:0] want_rw_slot,
	output logic cmd_act_valid,
	output logic [1:0] cmd_act_slot,
	output logic cmd_rw_valid,
	output logic [1:0] cmd_rw_slot
);
	// ----------------------------------------
	// scheduler issue
	// ----------------------------------------
	logic [1:0] idle_q;
	// slot lines wander while idle so a stale slot is never counted by luck
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idle_q <= 2'h0;
		end else begin
			idle_q <= idle_q + 2'h1;
		end
	end
	assign cmd_act_valid = want_act & ~req_block_q;
	assign cmd_rw_valid = want_rw & ~req_block_q;
	assign cmd_act_slot = want_act ? want_act_slot : idle_q;
	assign cmd_rw_slot = want_rw ? want_rw_slot : ~idle_q;
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam logic [7:0] LO = dat_pkg::OFS_CTRL_LOW;
	localparam logic [7:0] HI = dat_pkg::OFS_CTRL_HIGH;
	localparam logic [1:0] OK = dat_pkg::RESP_OKAY;
	localparam logic [1:0] DE = dat_pkg::RESP_DECERR;
	logic clk, rstn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, av, rv, cav, crv, blk, ton;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, as, rs, cas, crs;
	int errors, checks;
	dat_throttle #(.NSLOT(4), .MS_CYCLES(20), .US_CYCLES(4)) DUT (.clk(clk), .rstn(rstn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cmd_act_valid(cav), .cmd_act_slot(cas), .cmd_rw_valid(crv),
		.cmd_rw_slot(crs), .req_block_q(blk), .throttle_on_q(ton));
	dat_sched_model u_sched (.clk(clk), .rstn(rstn), .req_block_q(blk), .want_act(av), .want_act_slot(as),
		.want_rw(rv), .want_rw_slot(rs), .cmd_act_valid(cav), .cmd_act_slot(cas), .cmd_rw_valid(crv),
		.cmd_rw_slot(crs));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task stop_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic tmo(input string m);
		errors++;
		$display("Error at %0t: timeout on %s", $time, m);
		stop_test();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		if (n >= 50)
			tmo("write");
		chk(bresp, e, "bresp");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		if (n >= 50)
			tmo("read");
		chk(rdata, e, "rdata");
		chk(rresp, er, "rresp");
	endtask
	// s selects throttle_on_q, else req_block_q
	task automatic wt(input logic s, input logic v, input int lim, input string m);
		int n;
		n = 0;
		while ((s ? ton : blk) !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim)
			tmo(m);
		chk(s ? ton : blk, v, m);
	endtask
	task automatic cmd(input logic a, input logic [1:0] sa, input logic r, input logic [1:0] sr, input int n);
		@(posedge clk);
		av <= a;
		as <= sa;
		rv <= r;
		rs <= sr;
		repeat (n) @(posedge clk);
		av <= 1'b0;
		rv <= 1'b0;
	endtask
	// stop first so every case starts from cleared counters and a fresh window
	task automatic prep(input logic [1:0] c, input logic [11:0] t);
		wr(LO, {2'h0, c, 6'h00, 7'h7F, t, 3'h0}, OK);
		wr(LO, {2'h0, c, 6'h00, 7'h7F, t, 3'h1}, OK);
	endtask
	task automatic expb(input logic e);
		repeat (3) @(posedge clk);
		chk(blk, e, "block");
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rd(LO, dat_pkg::CTRL_LOW_RST, OK);
		rd(HI, dat_pkg::CTRL_HIGH_RST, OK);
		rd(8'h10, 32'h0000_0000, DE);
		wr(8'h10, 32'hFFFF_FFFF, DE);
		$display("test reset done");
	endtask
	task t_sw;
		wr(LO, 32'h0001_0020, OK);
		wr(LO, 32'h0001_0021, OK);
		wt(1'b1, 1'b1, 4, "sw on");
		cmd(1'b0, 2'h0, 1'b1, 2'h0, 2);
		wt(1'b0, 1'b1, 4, "block on");
		wt(1'b0, 1'b0, 40, "window end");
		wr(LO, 32'h0001_0020, OK);
		wt(1'b1, 1'b0, 4, "sw off");
		$display("test sw start done");
	endtask
	task t_wt;
		for (int c = 0; c < 4; c++) begin
			prep(c[1:0], 12'(c + 2));
			cmd(1'b1, 2'h1, 1'b0, 2'h0, 1);
			expb(1'b1);
			prep(c[1:0], 12'(c + 3));
			cmd(1'b1, 2'h1, 1'b0, 2'h0, 1);
			expb(1'b0);
		end
		prep(2'h0, 12'h004);
		cmd(1'b1, 2'h1, 1'b1, 2'h2, 1);
		cmd(1'b0, 2'h0, 1'b1, 2'h2, 1);
		expb(1'b1);
		prep(2'h0, 12'h004);
		cmd(1'b1, 2'h1, 1'b1, 2'h2, 1);
		cmd(1'b1, 2'h1, 1'b0, 2'h0, 1);
		expb(1'b1);
		prep(2'h0, 12'h004);
		cmd(1'b0, 2'h0, 1'b1, 2'h0, 1);
		cmd(1'b0, 2'h0, 1'b1, 2'h1, 1);
		expb(1'b0);
		$display("test weights done");
	endtask
	// commands seen while the clock enable is low must not count
	task t_ce;
		prep(2'h0, 12'h004);
		@(posedge clk);
		ce <= 1'b0;
		cmd(1'b0, 2'h0, 1'b1, 2'h0, 3);
		@(posedge clk);
		ce <= 1'b1;
		expb(1'b0);
		cmd(1'b0, 2'h0, 1'b1, 2'h0, 2);
		expb(1'b1);
		$display("test clock enable done");
	endtask
	task t_hw;
		wr(HI, 32'h2001_0001, OK);
		wr(LO, 32'h00BF_FFF8, OK);
		cmd(1'b0, 2'h0, 1'b1, 2'h0, 40);
		repeat (3) @(posedge clk);
		chk(ton, 1'b0, "mode off");
		wr(LO, 32'h00BF_FFFC, OK);
		cmd(1'b0, 2'h0, 1'b1, 2'h0, 40);
		wt(1'b1, 1'b1, 4, "hw on");
		wt(1'b1, 1'b0, 400, "hw end");
		cmd(1'b0, 2'h0, 1'b1, 2'h0, 40);
		wt(1'b1, 1'b1, 4, "hw again");
		wr(LO, 32'h00BF_FFF8, OK);
		wt(1'b1, 1'b0, 4, "hw off");
		$display("test hw done");
	endtask
	task t_lock;
		wr(HI, 32'h4000_0000, OK);
		wr(LO, 32'h0000_0001, OK);
		rd(LO, 32'h00BF_FFF9, OK);
		wr(HI, 32'h0000_0000, OK);
		rd(HI, 32'h4000_0000, OK);
		// only a reset lifts the lock, then the full lock is tried
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(HI, dat_pkg::CTRL_HIGH_RST, OK);
		wr(HI, 32'h8000_0000, OK);
		wr(LO, 32'h0000_0001, OK);
		rd(LO, dat_pkg::CTRL_LOW_RST, OK);
		wr(HI, 32'h0000_0000, OK);
		rd(HI, 32'h8000_0000, OK);
		$display("test lock done");
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		errors = 0;
		checks = 0;
		{rstn, awvalid, wvalid, bready, arvalid, rready, av, rv} = '0;
		{awaddr, araddr, as, rs} = '0;
		wdata = '0;
		ce = 1'b1;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_sw();
		t_wt();
		t_ce();
		t_hw();
		t_lock();
		stop_test();
	end
endmodule
